//--- pkg/mac_pkg.sv
// Package for the metering accumulation and zero-crossing configuration slice.
// Assumes a 12-bit register address space reached through the host serial port core.
package mac_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int POWER_W = 32;
  localparam int PERIOD_W = 32;
  localparam int NUM_PATHS = 4;
  localparam int NUM_PHASES = 3;
  localparam int SUM_W = POWER_W + 2;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ACCUM_MODE_ADDR = 12'h492;
  localparam logic [ADDR_W-1:0] PEAK_DETECT_CONFIG_ADDR = 12'h493;
  localparam logic [ADDR_W-1:0] ZERO_CROSS_PERIOD_SELECT_ADDR = 12'h49a;
  localparam logic [ADDR_W-1:0] POWER_SIGN_STATUS_ADDR = 12'h49d;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ACTIVE_ACCUM_LSB = 0;
  localparam int REACTIVE_ACCUM_LSB = 2;
  localparam int PEAK_ENABLE_LSB = 2;
  localparam int ZERO_CROSS_SRC_LSB = 1;
  localparam int LINE_PERIOD_SRC_LSB = 3;
  localparam int SUM_SIGN_LSB = 6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] ACCUM_MODE_RESET = 2'h0;
  localparam logic [2:0] PEAK_ENABLE_RESET = 3'h0;
  localparam logic [1:0] LINE_PERIOD_SRC_RESET = 2'h3;
  localparam logic [1:0] ZERO_CROSS_SRC_RESET = 2'h3;
  localparam logic [NUM_PATHS-1:0] SUM_SIGN_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ACCUM_SIGNED = 2'h0,
    ACCUM_ABSOLUTE = 2'h1,
    ACCUM_POSITIVE = 2'h2,
    ACCUM_NEGATIVE = 2'h3
  } mac_accum_mode_t;

  typedef enum logic [1:0]
  {
    SRC_PHASE_A = 2'h0,
    SRC_PHASE_B = 2'h1,
    SRC_PHASE_C = 2'h2,
    SRC_COMBINED = 2'h3
  } mac_source_t;

endpackage : mac_pkg

//--- pkg/mac_sign_if.sv
// Carrier between the register slice and the per-path power summing logic.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
`default_nettype none

interface mac_sign_if;
  import mac_pkg::*;

  logic signed [POWER_W-1:0] phase_power [NUM_PATHS][NUM_PHASES];
  logic [NUM_PHASES-1:0] phase_include [NUM_PATHS];
  logic [NUM_PATHS-1:0] sum_negative;

  modport slice
  (
    output phase_power,
    output phase_include,
    input sum_negative
  );

  modport summer
  (
    input phase_power,
    input phase_include,
    output sum_negative
  );

endinterface : mac_sign_if

`default_nettype wire

//--- rtl/mac_path_sign.sv
// Sums the enabled phase powers of each pulse datapath and gives the sign of each sum.
// Assumes the phase powers are already selected by type for each path elsewhere.
`timescale 1ns/1ns
`default_nettype none

module mac_path_sign
  import mac_pkg::*;
(
  // Power and inclusion in, signs out
  mac_sign_if.summer sig
);

  // ----------------------------------------------------------------
  // Per-path sum
  // ----------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < NUM_PATHS; p++)
    begin : g_path
      logic signed [SUM_W-1:0] sum;
      always_comb
      begin
        sum = '0;
        for (int ph = 0; ph < NUM_PHASES; ph++)
        begin
          // Excluded phases add nothing
          if (sig.phase_include[p][ph])
          begin
            sum = sum + SUM_W'(sig.phase_power[p][ph]);
          end
        end
      end
      // Negative sum flags the path
      assign sig.sum_negative[p] = sum[SUM_W-1];
    end
  endgenerate

endmodule : mac_path_sign

`default_nettype wire

//--- rtl/mac_config_slice.sv
// Accumulation mode, peak enable, line-period and zero-crossing selects, path sign status.
// Assumes the host serial port core presents a word-wide register port on the same clock.
`timescale 1ns/1ns
`default_nettype none

// Function
// - Reactive accumulation field at bits 3:2: signed, absolute, positive, negative.
// - Active accumulation field at bits 1:0, same four-value encoding.
// - Bits 4:2 enable peak detection per phase A, B, C; reset zero.
// - Line-period source at bits 4:3, reset 3; 0, 1, 2 pick phase A, B, C.
// - Line-period source 3 picks the period of the combined voltage signal.
// - Zero-crossing source at bits 2:1, reset 3; drives shared pin and line cycles.
// - Zero-crossing source 0, 1, 2 pick phases A, B, C; 3 the combined signal.
// - Status bits 9 to 6 show negative summed power of paths 4 to 1.
// - Sign bits are read-only, reset zero, updated only by the power computation.
// - Each path sums only the phases its three inclusion bits enable.
module mac_config_slice
  import mac_pkg::*;
(
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  // Register port from the host serial core
  input wire logic [ADDR_W-1:0] I_REG_ADDR,
  input wire logic I_REG_WRITE,
  input wire logic [DATA_W-1:0] I_REG_WDATA,
  input wire logic I_REG_READ,
  output logic [DATA_W-1:0] O_REG_RDATA,
  output logic O_REG_ACK,
  // Per-path phase powers, path p phase ph at index (p*3+ph)
  input wire logic [NUM_PATHS*NUM_PHASES*POWER_W-1:0] I_PATH_PHASE_POWER,
  input wire logic [NUM_PATHS*NUM_PHASES-1:0] I_PATH_PHASE_INCLUDE,
  // Line period measurements
  input wire logic [PERIOD_W-1:0] I_PHASE_A_PERIOD,
  input wire logic [PERIOD_W-1:0] I_PHASE_B_PERIOD,
  input wire logic [PERIOD_W-1:0] I_PHASE_C_PERIOD,
  input wire logic [PERIOD_W-1:0] I_COMBINED_PERIOD,
  // Zero-crossing signals
  input wire logic I_PHASE_A_VOLTAGE_CROSSING,
  input wire logic I_PHASE_B_VOLTAGE_CROSSING,
  input wire logic I_PHASE_C_VOLTAGE_CROSSING,
  input wire logic I_COMBINED_VOLTAGE_CROSSING,
  // Configuration out to the metering datapath
  output logic [1:0] O_REACTIVE_ACCUM_MODE,
  output logic [1:0] O_ACTIVE_ACCUM_MODE,
  output logic [NUM_PHASES-1:0] O_PEAK_PHASE_ENABLE,
  output logic [PERIOD_W-1:0] O_LINE_PERIOD,
  output logic O_ZERO_CROSS,
  output logic [NUM_PATHS-1:0] O_PATH_SUM_NEGATIVE
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  mac_accum_mode_t reactive_accum_mode;
  mac_accum_mode_t active_accum_mode;
  logic [NUM_PHASES-1:0] peak_phase_enable;
  mac_source_t line_period_source;
  mac_source_t zero_cross_source;
  logic [NUM_PATHS-1:0] path_sum_negative;
  logic [DATA_W-1:0] next_rdata;
  logic [PERIOD_W-1:0] next_line_period;
  logic next_zero_cross;

  mac_sign_if sign_bus ();

  // ----------------------------------------------------------------
  // Path summing
  // ----------------------------------------------------------------
  genvar p;
  genvar ph;
  generate
    for (p = 0; p < NUM_PATHS; p++)
    begin : g_path
      for (ph = 0; ph < NUM_PHASES; ph++)
      begin : g_phase
        assign sign_bus.phase_power[p][ph] =
          I_PATH_PHASE_POWER[(p*NUM_PHASES+ph)*POWER_W +: POWER_W];
        assign sign_bus.phase_include[p][ph] = I_PATH_PHASE_INCLUDE[p*NUM_PHASES+ph];
      end
    end
  endgenerate

  mac_path_sign u_path_sign
  (
    .sig (sign_bus.summer)
  );

  // ----------------------------------------------------------------
  // Software-written fields
  // ----------------------------------------------------------------
  // Only the named fields are stored, so reserved bits cannot hold writes
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      reactive_accum_mode <= mac_accum_mode_t'(ACCUM_MODE_RESET);
      active_accum_mode <= mac_accum_mode_t'(ACCUM_MODE_RESET);
    end
    else if (I_REG_WRITE && I_REG_ADDR == ACCUM_MODE_ADDR)
    begin
      reactive_accum_mode <= mac_accum_mode_t'(I_REG_WDATA[REACTIVE_ACCUM_LSB +: 2]);
      active_accum_mode <= mac_accum_mode_t'(I_REG_WDATA[ACTIVE_ACCUM_LSB +: 2]);
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      peak_phase_enable <= PEAK_ENABLE_RESET;
    end
    else if (I_REG_WRITE && I_REG_ADDR == PEAK_DETECT_CONFIG_ADDR)
    begin
      peak_phase_enable <= I_REG_WDATA[PEAK_ENABLE_LSB +: NUM_PHASES];
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      line_period_source <= mac_source_t'(LINE_PERIOD_SRC_RESET);
      zero_cross_source <= mac_source_t'(ZERO_CROSS_SRC_RESET);
    end
    else if (I_REG_WRITE && I_REG_ADDR == ZERO_CROSS_PERIOD_SELECT_ADDR)
    begin
      line_period_source <= mac_source_t'(I_REG_WDATA[LINE_PERIOD_SRC_LSB +: 2]);
      zero_cross_source <= mac_source_t'(I_REG_WDATA[ZERO_CROSS_SRC_LSB +: 2]);
    end
  end

  // ----------------------------------------------------------------
  // Sign status
  // ----------------------------------------------------------------
  // Writes to the status address never reach these bits
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      path_sum_negative <= SUM_SIGN_RESET;
    end
    else
    begin
      path_sum_negative <= sign_bus.sum_negative;
    end
  end

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (line_period_source)
      SRC_PHASE_A: next_line_period = I_PHASE_A_PERIOD;
      SRC_PHASE_B: next_line_period = I_PHASE_B_PERIOD;
      SRC_PHASE_C: next_line_period = I_PHASE_C_PERIOD;
      SRC_COMBINED: next_line_period = I_COMBINED_PERIOD;
    endcase
  end

  always_comb
  begin
    unique case (zero_cross_source)
      SRC_PHASE_A: next_zero_cross = I_PHASE_A_VOLTAGE_CROSSING;
      SRC_PHASE_B: next_zero_cross = I_PHASE_B_VOLTAGE_CROSSING;
      SRC_PHASE_C: next_zero_cross = I_PHASE_C_VOLTAGE_CROSSING;
      SRC_COMBINED: next_zero_cross = I_COMBINED_VOLTAGE_CROSSING;
    endcase
  end

  // One cycle of latency on both selects keeps the outputs glitch free
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      O_LINE_PERIOD <= '0;
      O_ZERO_CROSS <= 1'b0;
    end
    else
    begin
      O_LINE_PERIOD <= next_line_period;
      O_ZERO_CROSS <= next_zero_cross;
    end
  end

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = '0;
    unique case (I_REG_ADDR)
      ACCUM_MODE_ADDR:
      begin
        next_rdata[REACTIVE_ACCUM_LSB +: 2] = reactive_accum_mode;
        next_rdata[ACTIVE_ACCUM_LSB +: 2] = active_accum_mode;
      end
      PEAK_DETECT_CONFIG_ADDR:
      begin
        next_rdata[PEAK_ENABLE_LSB +: NUM_PHASES] = peak_phase_enable;
      end
      ZERO_CROSS_PERIOD_SELECT_ADDR:
      begin
        next_rdata[LINE_PERIOD_SRC_LSB +: 2] = line_period_source;
        next_rdata[ZERO_CROSS_SRC_LSB +: 2] = zero_cross_source;
      end
      POWER_SIGN_STATUS_ADDR:
      begin
        next_rdata[SUM_SIGN_LSB +: NUM_PATHS] = path_sum_negative;
      end
      default:
      begin
        next_rdata = '0;
      end
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      O_REG_RDATA <= '0;
      O_REG_ACK <= 1'b0;
    end
    else
    begin
      O_REG_RDATA <= I_REG_READ ? next_rdata : O_REG_RDATA;
      O_REG_ACK <= I_REG_READ | I_REG_WRITE;
    end
  end

  // ----------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------
  assign O_REACTIVE_ACCUM_MODE = reactive_accum_mode;
  assign O_ACTIVE_ACCUM_MODE = active_accum_mode;
  assign O_PEAK_PHASE_ENABLE = peak_phase_enable;
  assign O_PATH_SUM_NEGATIVE = path_sum_negative;

endmodule : mac_config_slice

`default_nettype wire

//--- testbench/mac_config_properties.sv
// Checker for the configuration slice; sees only the top-level ports.
// Assumes one clock domain and one-cycle registered answers.
`timescale 1ns/1ns
`default_nettype none
module mac_config_properties
  import mac_pkg::*;
(
  // Clock, reset and register port
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  input wire logic [ADDR_W-1:0] I_REG_ADDR,
  input wire logic I_REG_WRITE,
  input wire logic [DATA_W-1:0] I_REG_WDATA,
  input wire logic I_REG_READ,
  input wire logic [DATA_W-1:0] O_REG_RDATA,
  input wire logic O_REG_ACK,
  // Datapath side
  input wire logic I_PHASE_A_VOLTAGE_CROSSING,
  input wire logic [PERIOD_W-1:0] I_COMBINED_PERIOD,
  input wire logic [1:0] O_REACTIVE_ACCUM_MODE,
  input wire logic [1:0] O_ACTIVE_ACCUM_MODE,
  input wire logic [NUM_PHASES-1:0] O_PEAK_PHASE_ENABLE,
  input wire logic [PERIOD_W-1:0] O_LINE_PERIOD,
  input wire logic O_ZERO_CROSS,
  input wire logic [NUM_PATHS-1:0] O_PATH_SUM_NEGATIVE
);
  default clocking @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RESET_N);
  // Select writes are followed by a quiet cycle so the new source is settled
  wire logic wr_sel = I_REG_WRITE && I_REG_ADDR == ZERO_CROSS_PERIOD_SELECT_ADDR;
  ack_follows_strobe_a: assert property ((I_REG_WRITE || I_REG_READ) |=> O_REG_ACK)
    else $error("ack missing after strobe");
  ack_needs_strobe_a: assert property (!(I_REG_WRITE || I_REG_READ) |=> !O_REG_ACK)
    else $error("ack without strobe");
  rdata_holds_a: assert property (!I_REG_READ |=> $stable(O_REG_RDATA))
    else $error("read data moved without read");
  accum_write_a: assert property (
    I_REG_WRITE && I_REG_ADDR == ACCUM_MODE_ADDR |=>
    {O_REACTIVE_ACCUM_MODE, O_ACTIVE_ACCUM_MODE} == $past(I_REG_WDATA[3:0]))
    else $error("accumulation modes not written");
  peak_write_a: assert property (
    I_REG_WRITE && I_REG_ADDR == PEAK_DETECT_CONFIG_ADDR |=>
    O_PEAK_PHASE_ENABLE == $past(I_REG_WDATA[4:2]))
    else $error("peak enable not written");
  zero_cross_a: assert property (
    wr_sel && I_REG_WDATA[2:1] == 2'h0 ##1 !wr_sel |=>
    O_ZERO_CROSS == $past(I_PHASE_A_VOLTAGE_CROSSING))
    else $error("phase A crossing not selected");
  line_period_a: assert property (
    wr_sel && I_REG_WDATA[4:3] == 2'h3 ##1 !wr_sel |=>
    O_LINE_PERIOD == $past(I_COMBINED_PERIOD))
    else $error("combined period not selected");
  sign_readback_a: assert property (
    I_REG_READ && I_REG_ADDR == POWER_SIGN_STATUS_ADDR |=>
    O_REG_RDATA == {6'h0, $past(O_PATH_SUM_NEGATIVE), 6'h0})
    else $error("sign status read wrong");
  select_reserved_a: assert property (
    I_REG_READ && I_REG_ADDR == ZERO_CROSS_PERIOD_SELECT_ADDR |=>
    (O_REG_RDATA & 16'hffe1) == 16'h0)
    else $error("reserved select bits not zero");
  cover property (wr_sel ##2 O_ZERO_CROSS);
  cover property (I_REG_READ && I_REG_ADDR == POWER_SIGN_STATUS_ADDR ##1 O_REG_RDATA != 0);
  cover property (O_PATH_SUM_NEGATIVE == 4'h9);
endmodule : mac_config_properties
bind mac_config_slice mac_config_properties u_props
(
  .I_CLOCK (I_CLOCK),
  .I_RESET_N (I_RESET_N),
  .I_REG_ADDR (I_REG_ADDR),
  .I_REG_WRITE (I_REG_WRITE),
  .I_REG_WDATA (I_REG_WDATA),
  .I_REG_READ (I_REG_READ),
  .O_REG_RDATA (O_REG_RDATA),
  .O_REG_ACK (O_REG_ACK),
  .I_PHASE_A_VOLTAGE_CROSSING (I_PHASE_A_VOLTAGE_CROSSING),
  .I_COMBINED_PERIOD (I_COMBINED_PERIOD),
  .O_REACTIVE_ACCUM_MODE (O_REACTIVE_ACCUM_MODE),
  .O_ACTIVE_ACCUM_MODE (O_ACTIVE_ACCUM_MODE),
  .O_PEAK_PHASE_ENABLE (O_PEAK_PHASE_ENABLE),
  .O_LINE_PERIOD (O_LINE_PERIOD),
  .O_ZERO_CROSS (O_ZERO_CROSS),
  .O_PATH_SUM_NEGATIVE (O_PATH_SUM_NEGATIVE)
);
`default_nettype wire

//--- testbench/test_metering_accum_zx_config.sv
// Self-checking bench for the configuration slice, driving every port itself.
// Assumes the strobe/ack register port and one-cycle registered outputs.
`timescale 1ns/1ns
`default_nettype none
module test_metering_accum_zx_config
  import mac_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n;
  logic [ADDR_W-1:0] addr = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic ack;
  logic [NUM_PATHS*NUM_PHASES*POWER_W-1:0] power = '0;
  logic [11:0] incl = '0;
  logic [PERIOD_W-1:0] per [4] = '{32'h11, 32'h22, 32'h33, 32'h44};
  logic [3:0] zx = '0;
  logic [1:0] racc, aacc;
  logic [2:0] peak;
  logic [PERIOD_W-1:0] lp;
  logic zc;
  logic [3:0] sneg;
  int err_count = 0;
  int compares = 0;
  always #25 clk = ~clk;
  mac_config_slice DUT (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_REG_ADDR(addr),
    .I_REG_WRITE(wr), .I_REG_WDATA(wdata), .I_REG_READ(rd), .O_REG_RDATA(rdata),
    .O_REG_ACK(ack), .I_PATH_PHASE_POWER(power), .I_PATH_PHASE_INCLUDE(incl),
    .I_PHASE_A_PERIOD(per[0]), .I_PHASE_B_PERIOD(per[1]), .I_PHASE_C_PERIOD(per[2]),
    .I_COMBINED_PERIOD(per[3]), .I_PHASE_A_VOLTAGE_CROSSING(zx[0]),
    .I_PHASE_B_VOLTAGE_CROSSING(zx[1]), .I_PHASE_C_VOLTAGE_CROSSING(zx[2]),
    .I_COMBINED_VOLTAGE_CROSSING(zx[3]), .O_REACTIVE_ACCUM_MODE(racc),
    .O_ACTIVE_ACCUM_MODE(aacc), .O_PEAK_PHASE_ENABLE(peak), .O_LINE_PERIOD(lp),
    .O_ZERO_CROSS(zc), .O_PATH_SUM_NEGATIVE(sneg));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    chk("write ack", 32'h1, {31'h0, ack});
  endtask : wr_reg
  task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk("read ack", 32'h1, {31'h0, ack});
    chk(what, {16'h0, exp}, {16'h0, rdata});
  endtask : rd_chk
  // Path 3 carries full-scale powers: a 32-bit sum of two of them would wrap negative
  task automatic sign_case(input logic [11:0] inc, input logic [3:0] exp);
    incl = inc;
    @(negedge clk);
    chk("path sign", {28'h0, exp}, {28'h0, sneg});
    rd_chk("sign status", POWER_SIGN_STATUS_ADDR, {6'h0, exp, 6'h0});
  endtask : sign_case
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  initial
  begin
    #200000;
    err_count++;
    end_sim();
  end
  initial
  begin
    // Drive reset at time zero so the asynchronous branch fires before any clock edge
    rst_n = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    rd_chk("accum reset", ACCUM_MODE_ADDR, 16'h0);
    rd_chk("peak reset", PEAK_DETECT_CONFIG_ADDR, 16'h0);
    rd_chk("select reset", ZERO_CROSS_PERIOD_SELECT_ADDR, 16'h001e);
    rd_chk("sign reset", POWER_SIGN_STATUS_ADDR, 16'h0);
    for (int v = 0; v < 4; v++)
    begin
      wr_reg(ACCUM_MODE_ADDR, 16'(v * 4 + 3 - v));
      chk("reactive mode", 32'(v), {30'h0, racc});
      chk("active mode", 32'(3 - v), {30'h0, aacc});
      wr_reg(PEAK_DETECT_CONFIG_ADDR, 16'(4 << v));
      chk("peak enable", 32'((1 << v) & 7), {29'h0, peak});
      wr_reg(ZERO_CROSS_PERIOD_SELECT_ADDR, 16'(v * 10));
      zx = 4'(1 << v);
      @(negedge clk);
      chk("line period", per[v], lp);
      chk("zero cross high", 32'h1, {31'h0, zc});
      zx = ~zx;
      @(negedge clk);
      chk("zero cross low", 32'h0, {31'h0, zc});
    end
    wr_reg(ACCUM_MODE_ADDR, 16'hffff);
    rd_chk("accum read", ACCUM_MODE_ADDR, 16'h000f);
    wr_reg(PEAK_DETECT_CONFIG_ADDR, 16'hffff);
    rd_chk("peak read", PEAK_DETECT_CONFIG_ADDR, 16'h001c);
    wr_reg(ZERO_CROSS_PERIOD_SELECT_ADDR, 16'hffff);
    rd_chk("select read", ZERO_CROSS_PERIOD_SELECT_ADDR, 16'h001e);
    wr_reg(POWER_SIGN_STATUS_ADDR, 16'hffff);
    rd_chk("sign write", POWER_SIGN_STATUS_ADDR, 16'h0);
    rd_chk("unmapped", 12'h123, 16'h0);
    for (int p = 0; p < 4; p++)
      for (int ph = 0; ph < 3; ph++)
        power[(p * 3 + ph) * 32 +: 32] = (p == 2) ? 32'h7fffffff :
          (ph == 0) ? 32'hfffffffb : (ph == 1) ? 32'h0000000a : 32'hffffff9c;
    sign_case({3'h6, 3'h7, 3'h3, 3'h1}, 4'h9);
    sign_case({3'h3, 3'h3, 3'h4, 3'h2}, 4'h2);
    end_sim();
  end
endmodule : test_metering_accum_zx_config
`default_nettype wire
